/* File: hdl/ddr_burst2_pkg.sv */
package ddr_burst2_pkg;

  localparam int DW_NARROW    = 18;
  localparam int DW_WIDE      = 36;
  localparam int LANE_W       = 9;
  localparam int UA_W_NARROW  = 19;
  localparam int UA_W_WIDE    = 18;
  localparam int ADDR_MAX_W   = 20;
  localparam int BURST_LEN    = 2;
  localparam int FIFO_DEPTH   = 4;
  localparam int MEM_AW_DEF   = 10;

  localparam int MCLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_CYCLES    = LINK_PERIOD_NS / MCLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ  = 2'h2
  } cycle_state_e;

  typedef struct packed {
    logic                  read;
    logic [ADDR_MAX_W-1:0] addr;
  } bus_cycle_s;

endpackage

/* File: hdl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  buf_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_r != (PW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = buf_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      buf_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

/* File: hdl/ddr_burst2_sram.sv */
`timescale 1ns/1ps
module ddr_burst2_sram #(
  parameter int DW     = ddr_burst2_pkg::DW_NARROW,
  parameter int UA_W   = (DW == ddr_burst2_pkg::DW_WIDE) ? ddr_burst2_pkg::UA_W_WIDE : ddr_burst2_pkg::UA_W_NARROW,
  parameter int NB     = DW / ddr_burst2_pkg::LANE_W,
  parameter int MEM_AW = ddr_burst2_pkg::MEM_AW_DEF
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            input_clock_true,
  input  wire logic            input_clock_comp,
  input  wire logic            output_clock_true,
  input  wire logic            output_clock_comp,
  input  wire logic            cycle_load_n,
  input  wire logic            read_write_sel,
  input  wire logic            burst_low_address_bit,
  input  wire logic [UA_W-1:0] upper_address_inputs,
  input  wire logic [NB-1:0]   byte_write_select_n,
  input  wire logic [DW-1:0]   data_in,
  output logic      [DW-1:0]   data_out,
  output logic                 data_oe,
  output logic                 echo_clock_true,
  output logic                 echo_clock_comp
);
  import ddr_burst2_pkg::*;

  localparam int PW = 7 + UA_W + NB + DW;

  function automatic logic [MEM_AW-1:0] mem_index(input logic [ADDR_MAX_W-1:0] a);
    mem_index = a[MEM_AW-1:0];
  endfunction

  logic [PW-1:0]         pin_s1_r;
  logic [PW-1:0]         pin_s2_r;
  logic [3:0]            clk_d_r;
  logic                  k_s, kn_s, c_s, cn_s;
  logic                  k_d, kn_d, c_d, cn_d;
  logic                  ld_n_s;
  logic                  rw_s;
  logic                  a0_s;
  logic [UA_W-1:0]       ua_s;
  logic [NB-1:0]         bw_n_s;
  logic [DW-1:0]         din_s;
  logic                  k_rise;
  logic                  kn_rise;
  logic                  c_tied;
  logic                  ot, oc, ot_d, oc_d;
  logic                  ot_rise;
  logic                  oc_rise;
  logic [ADDR_MAX_W-1:0] addr_in_w;
  cycle_state_e          state_r;
  bus_cycle_s            cyc_r;
  logic [1:0]            cnt_r;
  logic                  we_first;
  logic                  we_second;
  logic                  we;
  logic [ADDR_MAX_W-1:0] wa;
  logic [ADDR_MAX_W-1:0] ra;
  logic [DW-1:0]         mem [2**MEM_AW];
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  push;
  logic                  fifo_out_valid;
  logic [DW-1:0]         fifo_out_data;
  logic                  pop;
  logic                  slot_r;
  logic                  oe_r;
  logic [DW-1:0]         dout_r;
  logic                  echo_t_r;
  logic                  echo_c_r;

  // All pins share one two-stage synchroniser so data keeps its alignment with the clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {input_clock_true, input_clock_comp, output_clock_true, output_clock_comp, cycle_load_n,
                   read_write_sel, burst_low_address_bit, upper_address_inputs, byte_write_select_n, data_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {k_s, kn_s, c_s, cn_s, ld_n_s, rw_s, a0_s, ua_s, bw_n_s, din_s} = pin_s2_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_d_r <= 4'h0;
    end else begin
      clk_d_r <= {k_s, kn_s, c_s, cn_s};
    end
  end

  assign {k_d, kn_d, c_d, cn_d} = clk_d_r;
  assign k_rise    = k_s & ~k_d;
  assign kn_rise   = kn_s & ~kn_d;
  assign addr_in_w = ADDR_MAX_W'({ua_s, a0_s});

  // Complementary clocks are never both high for two samples unless tied
  assign c_tied  = c_s & cn_s & c_d & cn_d;
  assign ot      = c_tied ? k_s : c_s;
  assign oc      = c_tied ? kn_s : cn_s;
  assign ot_d    = c_tied ? k_d : c_d;
  assign oc_d    = c_tied ? kn_d : cn_d;
  assign ot_rise = ot & ~ot_d;
  assign oc_rise = oc & ~oc_d;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else if (k_rise) begin
      if (!ld_n_s) begin
        state_r <= rw_s ? ST_READ : ST_WRITE;
      end else begin
        state_r <= ST_IDLE;
      end
    end
  end

  // Address is taken only at a loading edge, so it is ignored in idle and mid-burst
  always_ff @(posedge mclk) begin
    if (rst) begin
      cyc_r <= '0;
    end else if (k_rise && !ld_n_s) begin
      cyc_r.read <= rw_s;
      cyc_r.addr <= addr_in_w;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 2'h0;
    end else if (k_rise && !ld_n_s) begin
      cnt_r <= rw_s ? 2'h0 : 2'h1;
    end else if (we_second || push) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  assign we_first  = k_rise & ~ld_n_s & ~rw_s;
  assign we_second = (state_r == ST_WRITE) && kn_rise && (cnt_r == 2'(BURST_LEN - 1));
  assign we        = we_first | we_second;
  assign wa        = we_first ? addr_in_w : {cyc_r.addr[ADDR_MAX_W-1:1], ~cyc_r.addr[0]};

  always_ff @(posedge mclk) begin
    if (we) begin
      for (int i = 0; i < NB; i++) begin
        if (!bw_n_s[i]) begin
          mem[mem_index(wa)][i*LANE_W +: LANE_W] <= din_s[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Reads stall while the FIFO is full, so pushes run ahead of the output clocks, held back only by back-pressure
  assign ra            = {cyc_r.addr[ADDR_MAX_W-1:1], cyc_r.addr[0] ^ cnt_r[0]};
  assign fifo_in_valid = (state_r == ST_READ) && (cnt_r < 2'(BURST_LEN));
  assign push          = fifo_in_valid & fifo_in_ready;

  word_fifo #(
    .W     (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_read_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (mem[mem_index(ra)]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  assign pop = fifo_out_valid & ((ot_rise & ~slot_r) | (oc_rise & slot_r));

  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_r <= 1'b0;
      oe_r   <= 1'b0;
      dout_r <= '0;
    end else if (pop) begin
      dout_r <= fifo_out_data;
      oe_r   <= 1'b1;
      slot_r <= ~slot_r;
    end else if (ot_rise) begin
      oe_r   <= 1'b0;
      slot_r <= 1'b0;
    end
  end

  // Echo clocks follow whichever pair times the outputs, never gated by the data enable
  always_ff @(posedge mclk) begin
    if (rst) begin
      echo_t_r <= 1'b0;
      echo_c_r <= 1'b0;
    end else begin
      echo_t_r <= ot;
      echo_c_r <= oc;
    end
  end

  assign data_out        = dout_r;
  assign data_oe         = oe_r;
  assign echo_clock_true = echo_t_r;
  assign echo_clock_comp = echo_c_r;

  logic [7:0] echo_still_r;
  always_ff @(posedge mclk) begin
    if (rst || (echo_t_r != ot)) begin
      echo_still_r <= 8'h0;
    end else if (echo_still_r != 8'hff) begin
      echo_still_r <= echo_still_r + 8'h1;
    end
  end

  sequence s_read_load;
    k_rise && !ld_n_s && rw_s;
  endsequence

  sequence s_two_pushes;
    ##[1:8] push ##[1:8] push;
  endsequence

  property p_capture;
    @(posedge mclk) disable iff (rst) (k_rise && !ld_n_s) |=> cyc_r.addr == $past(addr_in_w);
  endproperty
  a_capture: assert property (p_capture) else $error("address not captured at load");

  property p_ignore;
    @(posedge mclk) disable iff (rst) !(k_rise && !ld_n_s) |=> $stable(cyc_r.addr);
  endproperty
  a_ignore: assert property (p_ignore) else $error("address changed without load");

  property p_second_addr;
    @(posedge mclk) disable iff (rst)
      we_second |-> (wa[0] != cyc_r.addr[0]) && (wa[ADDR_MAX_W-1:1] == cyc_r.addr[ADDR_MAX_W-1:1]);
  endproperty
  a_second_addr: assert property (p_second_addr) else $error("second write address wrong");

  property p_count;
    @(posedge mclk) disable iff (rst) cnt_r <= 2'(BURST_LEN);
  endproperty
  a_count: assert property (p_count) else $error("burst count past two");

  property p_select;
    @(posedge mclk) disable iff (rst)
      k_rise |=> state_r == ($past(ld_n_s) ? ST_IDLE : ($past(rw_s) ? ST_READ : ST_WRITE));
  endproperty
  a_select: assert property (p_select) else $error("wrong cycle decode");

  property p_state_hold;
    @(posedge mclk) disable iff (rst) !k_rise |=> $stable(state_r);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved off input clock edge");

  property p_drive;
    @(posedge mclk) disable iff (rst)
      (ot_rise && !slot_r && fifo_out_valid) |=> oe_r && (data_out == $past(fifo_out_data));
  endproperty
  a_drive: assert property (p_drive) else $error("first read word not driven");

  property p_read_two;
    @(posedge mclk) disable iff (rst) s_read_load |-> s_two_pushes;
  endproperty
  a_read_two: assert property (p_read_two) else $error("read burst not two words");

  property p_echo;
    @(posedge mclk) disable iff (rst) echo_still_r < 8'(LINK_CYCLES);
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock stopped");

  property p_release;
    @(posedge mclk) disable iff (rst) (ot_rise && !fifo_out_valid) |=> !oe_r;
  endproperty
  a_release: assert property (p_release) else $error("bus driven without read data");

endmodule

/* File: verif/ddr_ctrl_model.sv */
`timescale 1ns/1ps
module ddr_ctrl_model #(
  parameter int DW   = 18,
  parameter int UA_W = 19,
  parameter int NB   = 2
) (
  output logic            k_true,
  output logic            k_comp,
  output logic            c_true,
  output logic            c_comp,
  output logic            load_n,
  output logic            rw_sel,
  output logic            addr_lo,
  output logic [UA_W-1:0] addr_hi,
  output logic [NB-1:0]   bw_n,
  output logic [DW-1:0]   dq,
  input  wire logic       c_run
);
  initial begin
    {load_n, rw_sel, addr_lo, bw_n} = '1;
    addr_hi = '0;
    dq = '0;
    k_true = 1'b0;
    #37;
    forever #400 k_true = ~k_true;
  end
  assign k_comp = ~k_true;
  // Tied high selects input-pair timing; never toggled while tied
  always @(k_true) c_true <= #200 (c_run ? k_true : 1'b1);
  always @(k_true) c_comp <= #200 (c_run ? ~k_true : 1'b1);
  // One load per input period; lines move 200 ns after an edge
  task automatic op(input logic ld, input logic rd, input logic [UA_W:0] a,
                    input logic [DW-1:0] w0, input logic [DW-1:0] w1, input logic [2*NB-1:0] bw);
    @(negedge k_true);
    #200;
    load_n = ~ld;
    rw_sel = rd;
    {addr_hi, addr_lo} = a;
    bw_n = bw[NB-1:0];
    dq = rd ? ~dq : w0;
    @(posedge k_true);
    #200;
    load_n = 1'b1;
    // Garbage address while the burst completes
    {addr_hi, addr_lo} = ~a;
    bw_n = bw[2*NB-1:NB];
    dq = rd ? ~dq : w1;
  endtask
endmodule

/* File: verif/ddr_burst2_sram_tb_top.sv */
`timescale 1ns/1ps
module ddr_burst2_sram_tb_top;
  import ddr_burst2_pkg::*;
  localparam int UA = UA_W_NARROW;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 c_run = 1'b0;
  logic                 k_t, k_c, c_t, c_c, load_n, rw_sel, a_lo, oe, eq_t, eq_c;
  logic [UA-1:0]        a_hi;
  logic [1:0]           bw_n;
  logic [DW_NARROW-1:0] din, dout;
  logic [DW_NARROW-1:0] got[$], exp_q[$];
  logic [DW_NARROW-1:0] shadow [0:1023];
  int                   n_fail = 0, tests_run = 0, oe_hits = 0, eq_edges = 0, cyc = 0;
  int                   eq_c_edges = 0;

  always #50 mclk = ~mclk;

  ddr_ctrl_model #(.DW(DW_NARROW), .UA_W(UA), .NB(2)) u_ctrl (
    .k_true(k_t), .k_comp(k_c), .c_true(c_t), .c_comp(c_c), .load_n(load_n), .rw_sel(rw_sel),
    .addr_lo(a_lo), .addr_hi(a_hi), .bw_n(bw_n), .dq(din), .c_run(c_run));

  ddr_burst2_sram #(.DW(DW_NARROW)) dut (
    .mclk(mclk), .rst(rst), .input_clock_true(k_t), .input_clock_comp(k_c),
    .output_clock_true(c_t), .output_clock_comp(c_c), .cycle_load_n(load_n),
    .read_write_sel(rw_sel), .burst_low_address_bit(a_lo), .upper_address_inputs(a_hi),
    .byte_write_select_n(bw_n), .data_in(din), .data_out(dout), .data_oe(oe),
    .echo_clock_true(eq_t), .echo_clock_comp(eq_c));

  // Word launched at one edge is still standing 100 ns after the next edge
  wire ref_t = c_run ? c_t : k_t;
  wire ref_c = c_run ? c_c : k_c;
  always @(posedge ref_t or posedge ref_c) begin
    #100;
    if (oe === 1'b1) got.push_back(dout);
  end
  always @(posedge mclk) if (oe === 1'b1) oe_hits++;
  always @(posedge eq_t or posedge eq_c) eq_edges++;
  always @(posedge eq_c) eq_c_edges++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  task automatic check(input logic [DW_NARROW-1:0] g, input logic [DW_NARROW-1:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic void put(input logic [UA:0] a, input logic [DW_NARROW-1:0] w, input logic [1:0] bw);
    for (int i = 0; i < 2; i++) if (!bw[i]) shadow[a[9:0]][9*i+:9] = w[9*i+:9];
  endfunction

  task automatic wr(input logic [UA:0] a, input logic [DW_NARROW-1:0] w0, w1, input logic [3:0] bw);
    put(a, w0, bw[1:0]);
    put(a ^ 20'h00001, w1, bw[3:2]);
    u_ctrl.op(1'b1, 1'b0, a, w0, w1, bw);
  endtask

  task automatic rd(input logic [UA:0] a);
    exp_q.push_back(shadow[a[9:0]]);
    exp_q.push_back(shadow[a[9:0] ^ 10'h001]);
    u_ctrl.op(1'b1, 1'b1, a, '0, '0, 4'hf);
  endtask

  task automatic drain(input string m);
    repeat (4) @(posedge k_t);
    check(DW_NARROW'(got.size()), DW_NARROW'(exp_q.size()), {m, " count"});
    while (got.size() > 0 && exp_q.size() > 0) check(got.pop_front(), exp_q.pop_front(), m);
    got = {};
    exp_q = {};
    $display("test %s done", m);
  endtask

  task automatic t_basic;
    oe_hits = 0;
    wr(20'h00010, 18'h0a5a5, 18'h15a5a, 4'h0);
    wr(20'h00013, 18'h01234, 18'h3abcd, 4'h0);
    check(DW_NARROW'(oe_hits), '0, "oe in write");
    rd(20'h00010);
    rd(20'h00013);
    rd(20'h00012);
    drain("basic");
  endtask

  task automatic t_lanes;
    wr(20'h00020, 18'h11111, 18'h22222, 4'h0);
    wr(20'h00020, 18'h3ffff, 18'h00000, 4'h9);
    rd(20'h00020);
    drain("lanes");
  endtask

  task automatic t_nop;
    wr(20'h00030, 18'h0f0f0, 18'h30303, 4'h0);
    u_ctrl.op(1'b0, 1'b0, 20'h00030, 18'h2dead, 18'h1beef, 4'h0);
    u_ctrl.op(1'b0, 1'b1, 20'h00030, '0, '0, 4'hf);
    rd(20'h00031);
    drain("nop");
  endtask

  task automatic t_crun;
    c_run = 1'b1;
    repeat (3) @(posedge k_t);
    rd(20'h00010);
    wr(20'h00041, 18'h2aaaa, 18'h15555, 4'h0);
    rd(20'h00040);
    rd(20'h00013);
    drain("crun");
    c_run = 1'b0;
    repeat (3) @(posedge k_t);
  endtask

  task automatic t_echo;
    int n0;
    int n1;
    oe_hits = 0;
    n0 = eq_edges;
    n1 = eq_c_edges;
    repeat (4) @(posedge k_t);
    check(DW_NARROW'(eq_edges - n0 >= 7), 18'h00001, "echo toggles");
    check(DW_NARROW'(eq_c_edges - n1 >= 3), 18'h00001, "echo comp toggles");
    check(DW_NARROW'(oe_hits), '0, "oe idle");
    $display("test echo done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #10 rst = 1'b0;
    repeat (5) @(posedge mclk);
    t_basic();
    t_lanes();
    t_nop();
    t_crun();
    t_echo();
    close_out();
  end
endmodule
